// ===== pkg/ccd_pkg.sv
// constants and types for the clear, complement and decrement executor
package ccd_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_INSTR = 5'h00;
  localparam logic [4:0] OFF_ACCUM = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_WDOG = 5'h0c;
  localparam logic [4:0] OFF_PRESC = 5'h10;
  localparam logic [4:0] OFF_PC = 5'h14;
  localparam logic [4:0] OFF_FADDR = 5'h18;
  localparam logic [4:0] OFF_FDATA = 5'h1c;
  // status field positions
  localparam int Z_POS = 2;
  localparam int PWRDN_POS = 3;
  localparam int TMO_POS = 4;
  // reset values
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic Z_RST = 1'b0;
  localparam logic TMO_RST = 1'b1;
  localparam logic PWRDN_RST = 1'b1;
  // watchdog timing
  localparam logic [7:0] PRESC_MAX = 8'hff;
  localparam logic [7:0] WDOG_MAX = 8'hff;
  // encodings
  localparam logic [13:0] ENC_CLR_ACC = 14'h0103;
  localparam logic [13:0] ENC_WDOG_CLR = 14'h0064;
  localparam logic [5:0] ENC_COMP_HI = 6'h09;
  localparam logic [5:0] ENC_DEC_HI = 6'h03;
  localparam logic [6:0] ENC_CLR_FILE_HI = 7'h03;
  localparam int FILE_DEPTH = 128;
  typedef enum logic [2:0] {
    op_none, clear_accumulator_op, complement_file_op,
    watchdog_clear_op, decrement_file_op, clear_file_op
  } op_e;
endpackage : ccd_pkg

// ===== logic/ccd_file_ram.sv
// data register file, 128 bytes of flip-flops
`timescale 1ns/10ps
module ccd_file_ram import ccd_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [FILE_DEPTH];
  logic [7:0] mem_d [FILE_DEPTH];

  always_comb begin
    mem_d = mem_q;
    if (we) begin
      mem_d[waddr] = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        mem_q[i] <= FILE_RST;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rdata = mem_q[raddr];
endmodule : ccd_file_ram

// ===== logic/clear_complement_decrement_exec.sv
// executor for clear, complement, decrement and watchdog-clear instructions
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module clear_complement_decrement_exec import ccd_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // status
  output logic zero_flag,
  output logic timeout_status_bit,
  output logic powerdown_status_bit
);
  function automatic op_e decode(input logic [13:0] w);
    if (w == ENC_CLR_ACC) begin
      return clear_accumulator_op;
    end else if (w == ENC_WDOG_CLR) begin
      return watchdog_clear_op;
    end else if (w[13:8] == ENC_COMP_HI) begin
      return complement_file_op;
    end else if (w[13:8] == ENC_DEC_HI) begin
      return decrement_file_op;
    end else if (w[13:7] == ENC_CLR_FILE_HI) begin
      return clear_file_op;
    end
    return op_none;
  endfunction : decode

  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] accum_q, accum_d;
  logic z_q, z_d, tmo_q, tmo_d, pwrdn_q, pwrdn_d;
  logic [7:0] wdog_q, wdog_d, presc_q, presc_d;
  logic [12:0] pc_q, pc_d;
  logic [6:0] faddr_q, faddr_d;
  logic file_we;
  logic [6:0] file_waddr, file_raddr;
  logic [7:0] file_wdata, file_rd, res;
  logic bus_go, exec_go, dbit;
  op_e op;

  ccd_file_ram u_file (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .we(file_we),
    .waddr(file_waddr),
    .wdata(file_wdata),
    .raddr(file_raddr),
    .rdata(file_rd)
  );

  always_comb begin
    bus_go = (avs_read || avs_write) && !wait_q;
    exec_go = avs_write && !wait_q && (avs_address == OFF_INSTR);
    op = decode(avs_writedata[13:0]);
    dbit = avs_writedata[7];
    file_raddr = exec_go ? avs_writedata[6:0] : faddr_q;
    res = 8'h00;
    // one wait state, then the answer
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if ((avs_read || avs_write) && wait_q && avs_read) begin
      rdata_d = 32'h0;
      unique case (avs_address)
        OFF_ACCUM: rdata_d[7:0] = accum_q;
        OFF_STATUS: begin
          rdata_d[Z_POS] = z_q;
          rdata_d[PWRDN_POS] = pwrdn_q;
          rdata_d[TMO_POS] = tmo_q;
        end
        OFF_WDOG: rdata_d[7:0] = wdog_q;
        OFF_PRESC: rdata_d[7:0] = presc_q;
        OFF_PC: rdata_d[12:0] = pc_q;
        OFF_FADDR: rdata_d[6:0] = faddr_q;
        OFF_FDATA: rdata_d[7:0] = file_rd;
        default: rdata_d = 32'h0;
      endcase
    end
    accum_d = accum_q;
    z_d = z_q;
    tmo_d = tmo_q;
    pwrdn_d = pwrdn_q;
    pc_d = pc_q;
    faddr_d = faddr_q;
    file_we = 1'b0;
    file_waddr = faddr_q;
    file_wdata = avs_writedata[7:0];
    // free-running watchdog; overflow drops the timeout bit
    presc_d = presc_q + 8'h01;
    wdog_d = wdog_q;
    if (presc_q == PRESC_MAX) begin
      wdog_d = wdog_q + 8'h01;
      if (wdog_q == WDOG_MAX) begin
        tmo_d = 1'b0;
      end
    end
    if (bus_go && avs_write && avs_byteenable[0]) begin
      unique case (avs_address)
        OFF_ACCUM: accum_d = avs_writedata[7:0];
        OFF_FADDR: faddr_d = avs_writedata[6:0];
        OFF_FDATA: file_we = 1'b1;
        default: ;
      endcase
    end
    if (exec_go) begin
      pc_d = pc_q + 13'h0001;
      file_waddr = avs_writedata[6:0];
      unique case (op)
        clear_accumulator_op: begin
          accum_d = 8'h00;
          z_d = 1'b1;
        end
        complement_file_op: begin
          res = ~file_rd;
          z_d = (res == 8'h00);
          if (dbit) begin
            file_we = 1'b1;
            file_wdata = res;
          end else begin
            accum_d = res;
          end
        end
        watchdog_clear_op: begin
          wdog_d = 8'h00;
          presc_d = 8'h00;
          tmo_d = 1'b1;
          pwrdn_d = 1'b1;
        end
        decrement_file_op: begin
          res = file_rd - 8'h01;
          z_d = (res == 8'h00);
          if (dbit) begin
            file_we = 1'b1;
            file_wdata = res;
          end else begin
            accum_d = res;
          end
        end
        clear_file_op: begin
          file_we = 1'b1;
          file_wdata = 8'h00;
          z_d = 1'b1;
        end
        op_none: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      accum_q <= ACCUM_RST;
      z_q <= Z_RST;
      tmo_q <= TMO_RST;
      pwrdn_q <= PWRDN_RST;
      wdog_q <= 8'h00;
      presc_q <= 8'h00;
      pc_q <= PC_RST;
      faddr_q <= 7'h00;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      accum_q <= accum_d;
      z_q <= z_d;
      tmo_q <= tmo_d;
      pwrdn_q <= pwrdn_d;
      wdog_q <= wdog_d;
      presc_q <= presc_d;
      pc_q <= pc_d;
      faddr_q <= faddr_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign zero_flag = z_q;
  assign timeout_status_bit = tmo_q;
  assign powerdown_status_bit = pwrdn_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_clr_acc_result: assert property (
    exec_go && op == clear_accumulator_op |=> accum_q == 8'h00 && z_q)
    else $error("accumulator clear failed");
  a_comp_dest_value: assert property (
    exec_go && op == complement_file_op && !dbit
    |=> accum_q == ~$past(file_rd) && z_q == ($past(file_rd) == 8'hff))
    else $error("complement to accumulator wrong");
  a_comp_keep_source: assert property (
    exec_go && op == complement_file_op && !dbit |-> !file_we ##1 $stable(pwrdn_q))
    else $error("complement disturbed source or status");
  a_wdog_clear_status: assert property (
    exec_go && op == watchdog_clear_op |=> wdog_q == 8'h00 && tmo_q && pwrdn_q)
    else $error("watchdog clear failed");
  a_presc_clear: assert property (
    exec_go && op == watchdog_clear_op |=> presc_q == 8'h00 ##1 presc_q == 8'h01)
    else $error("prescaler not cleared");
  a_dec_dest_value: assert property (
    exec_go && op == decrement_file_op
    |-> (dbit ? (file_we && file_wdata == file_rd - 8'h01) : !file_we))
    else $error("decrement result wrong");
  a_dec_zero_flag: assert property (
    exec_go && op == decrement_file_op
    |=> z_q == ($past(file_rd) == 8'h01) && $stable(pwrdn_q))
    else $error("decrement zero flag wrong");
  a_clear_file_zero: assert property (
    exec_go && op == clear_file_op |-> file_we && file_wdata == 8'h00 ##1 z_q)
    else $error("clear file failed");
  a_pc_step_one: assert property (
    exec_go |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("program counter did not step by one");
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer timing wrong");

  c_dec_to_zero: cover property (exec_go && op == decrement_file_op ##1 z_q);
  c_comp_to_file: cover property (exec_go && op == complement_file_op && dbit);
  c_wdog_clear: cover property (exec_go && op == watchdog_clear_op);
  c_timeout: cover property ($fell(tmo_q));
endmodule : clear_complement_decrement_exec

// ===== bench/fetch_model.sv
// bus-side model of the instruction fetch stage issuing avalon-mm transfers
`timescale 1ns/10ps
module fetch_model (
  // clock
  input wire logic sys_clk,
  // avalon-mm master
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // hang flag
  output logic hung
);
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    hung = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [4:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= addr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 20) begin
      hung = 1'b1;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines show garbage, not the last value
    avs_address <= ~addr;
    avs_writedata <= ~wd;
    @(posedge sys_clk);
  endtask : xfer
endmodule : fetch_model

// ===== bench/testbench.sv
// self-checking bench for the clear, complement and decrement executor
`timescale 1ns/10ps
module testbench import ccd_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic zero_flag;
  logic timeout_status_bit;
  logic powerdown_status_bit;
  logic hung;
  logic [31:0] r;
  int failures = 0;
  int n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  clear_complement_decrement_exec u_clear_complement_decrement_exec (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .zero_flag(zero_flag),
    .timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit));
  fetch_model u_fetch_model (
    .sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hung(hung));
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] wd);
    u_fetch_model.xfer(wr, addr, wd, r);
    if (hung) begin
      failures++;
      end_of_test();
    end
  endtask : bus
  task automatic expect_reg(input string what, input logic [4:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(what, r, exp);
  endtask : expect_reg
  task automatic exec(input logic [13:0] word);
    bus(1'b1, OFF_INSTR, {18'h0, word});
  endtask : exec
  task automatic poke(input logic [6:0] f, input logic [7:0] v);
    bus(1'b1, OFF_FADDR, {25'h0, f});
    bus(1'b1, OFF_FDATA, {24'h0, v});
  endtask : poke
  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    expect_reg("status", OFF_STATUS, 32'h18);
    expect_reg("accum", OFF_ACCUM, 32'h0);
    expect_reg("unmapped", 5'h02, 32'h0);
    bus(1'b1, OFF_STATUS, 32'h0);
    expect_reg("status ro", OFF_STATUS, 32'h18);
    poke(7'h05, 8'h13);
    exec(14'h0905);
    check("z comp w", zero_flag, 1'b0);
    expect_reg("accum comp", OFF_ACCUM, 32'hec);
    expect_reg("file kept", OFF_FDATA, 32'h13);
    // top file address
    poke(7'h7f, 8'hff);
    exec(14'h09ff);
    check("z comp f", zero_flag, 1'b1);
    expect_reg("file comp", OFF_FDATA, 32'h0);
    poke(7'h7f, 8'h01);
    exec(14'h03ff);
    check("z dec f", zero_flag, 1'b1);
    expect_reg("file dec", OFF_FDATA, 32'h0);
    exec(14'h037f);
    check("z dec w", zero_flag, 1'b0);
    expect_reg("accum dec", OFF_ACCUM, 32'hff);
    expect_reg("file dec kept", OFF_FDATA, 32'h0);
    poke(7'h7f, 8'h5a);
    exec(14'h01ff);
    check("z clear file", zero_flag, 1'b1);
    expect_reg("file cleared", OFF_FDATA, 32'h0);
    exec(14'h097f);
    check("z comp nonzero", zero_flag, 1'b0);
    exec(14'h0103);
    check("z clear acc", zero_flag, 1'b1);
    expect_reg("accum cleared", OFF_ACCUM, 32'h0);
    expect_reg("pc", OFF_PC, 32'h7);
    // let the watchdog run out
    repeat (66000) @(posedge sys_clk);
    check("timeout run out", timeout_status_bit, 1'b0);
    exec(ENC_WDOG_CLR);
    check("timeout", timeout_status_bit, 1'b1);
    check("powerdown", powerdown_status_bit, 1'b1);
    // cleared at the commit edge, one count per cycle until the read is sampled
    expect_reg("presc", OFF_PRESC, 32'h1);
    expect_reg("watchdog", OFF_WDOG, 32'h0);
    expect_reg("pc end", OFF_PC, 32'h8);
    end_of_test();
  end
endmodule : testbench
